/* File: core/frac_sub_pkg.sv */
// shared constants for the fractional subtract datapath
package frac_sub_pkg;
   // ------------------------------------------------------------
   // instruction field positions
   // ------------------------------------------------------------
   localparam int MAJOR_HI = 31;
   localparam int MAJOR_LO = 26;
   localparam int SUBOP_HI = 10;
   localparam int SUBOP_LO = 6;
   localparam int FUNC_HI  = 5;
   localparam int FUNC_LO  = 0;
   // ------------------------------------------------------------
   // datapath widths
   // ------------------------------------------------------------
   localparam int LANE_W  = 16;
   localparam int N_LANES = 2;
   localparam int WORD_W  = 32;
   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   localparam logic [5:0] EXTENSION_MAJOR_OPCODE   = 6'h1f;
   localparam logic [5:0] ARITH_FUNCTION_GROUP     = 6'h10;
   localparam logic [5:0] HALVING_FUNCTION_GROUP   = 6'h18;
   localparam logic [4:0] SUBOP_HALF_PAIR_SUB      = 5'h0b;
   localparam logic [4:0] SUBOP_HALF_PAIR_SUB_SAT  = 5'h0f;
   localparam logic [4:0] SUBOP_WORD_SUB_SAT       = 5'h17;
   localparam logic [4:0] SUBOP_HALVING_HALF       = 5'h09;
   localparam logic [4:0] SUBOP_HALVING_HALF_ROUND = 5'h0b;
   localparam logic [4:0] SUBOP_HALVING_WORD       = 5'h11;
   localparam logic [4:0] SUBOP_HALVING_WORD_ROUND = 5'h13;
   // ------------------------------------------------------------
   // control register and saturation values
   // ------------------------------------------------------------
   localparam int          OUFLAG_SUB_BIT = 20;
   localparam logic [15:0] HALF_MAX       = 16'h7fff;
   localparam logic [15:0] HALF_MIN       = 16'h8000;
   localparam logic [31:0] WORD_MAX       = 32'h7fffffff;
   localparam logic [31:0] WORD_MIN       = 32'h80000000;
   typedef enum {
      OP_NONE, OP_HPS, OP_HPS_SAT, OP_WS_SAT, OP_HH, OP_HH_R, OP_HW, OP_HW_R
   } sub_op_e;
endpackage : frac_sub_pkg

/* File: core/half_sub_lane.sv */
// one halfword lane: wrapped, saturated and halved differences
`timescale 1ns/1ps
module half_sub_lane
   import frac_sub_pkg::*;
(
   // operands
   input  wire logic [15:0] a_in,
   input  wire logic [15:0] b_in,
   // results
   output logic [15:0]      wrap_out,
   output logic [15:0]      sat_out,
   output logic [15:0]      half_out,
   output logic [15:0]      half_round_out,
   output logic             ovf_out
);
   logic [16:0] diff;
   logic [16:0] diff_r;
   assign diff           = {a_in[15], a_in} - {b_in[15], b_in};
   assign diff_r         = diff + 17'h00001;
   assign ovf_out        = diff[16] ^ diff[15];
   assign wrap_out       = diff[15:0];
   assign sat_out        = ovf_out ? (diff[16] ? HALF_MIN : HALF_MAX) : diff[15:0];
   assign half_out       = diff[16:1];
   assign half_round_out = diff_r[16:1];
endmodule : half_sub_lane

/* File: core/fractional_subtract_unit.sv */
// fractional subtract execution datapath with overflow flag
// Functional notes
// - decode saturating word subtract encoding
// - signed saturating Q31 word subtract
// - clamp to max or min word
// - word saturation sets control flag bit
// - word result sign-extended to 64 bits
// - halving halfword: 17-bit signed differences
// - halving halfword takes bits 16 to 1
// - rounding halfword adds one before shift
// - halving word: 33-bit difference shifted
// - rounding word adds one before shift
// - halving ops leave control register untouched
// - decode halving subtract encodings
// - no value-dependent exceptions raised
// - halfword saturate clamps, plain form wraps
// - halfword pair overflow sets flag bit
// - halfword pair result layout, sign-extended
`timescale 1ns/1ps
module fractional_subtract_unit
   import frac_sub_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        srst_in,
   // issue from pipeline
   input  wire logic        issue_valid_in,
   input  wire logic [31:0] instr_in,
   input  wire logic [63:0] first_source_in,
   input  wire logic [63:0] second_source_in,
   // control register write from software path
   input  wire logic        ctrl_wr_in,
   input  wire logic [31:0] ctrl_wdata_in,
   // results
   output logic             result_valid_out,
   output logic [63:0]      result_out,
   output logic [31:0]      sigproc_control_reg_out
);
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   function automatic sub_op_e decode_op(input logic [31:0] ins);
      sub_op_e op;
      op = OP_NONE;
      if (ins[MAJOR_HI:MAJOR_LO] == EXTENSION_MAJOR_OPCODE) begin
         if (ins[FUNC_HI:FUNC_LO] == ARITH_FUNCTION_GROUP) begin
            case (ins[SUBOP_HI:SUBOP_LO])
               SUBOP_HALF_PAIR_SUB:     op = OP_HPS;
               SUBOP_HALF_PAIR_SUB_SAT: op = OP_HPS_SAT;
               SUBOP_WORD_SUB_SAT:      op = OP_WS_SAT;
               default:                 op = OP_NONE;
            endcase
         end else if (ins[FUNC_HI:FUNC_LO] == HALVING_FUNCTION_GROUP) begin
            case (ins[SUBOP_HI:SUBOP_LO])
               SUBOP_HALVING_HALF:       op = OP_HH;
               SUBOP_HALVING_HALF_ROUND: op = OP_HH_R;
               SUBOP_HALVING_WORD:       op = OP_HW;
               SUBOP_HALVING_WORD_ROUND: op = OP_HW_R;
               default:                  op = OP_NONE;
            endcase
         end
      end
      return op;
   endfunction : decode_op

   // ------------------------------------------------------------
   // result shaping
   // ------------------------------------------------------------
   function automatic logic [63:0] sext32(input logic [31:0] v);
      return {{WORD_W{v[WORD_W-1]}}, v};
   endfunction : sext32

   // upper lane sign lands on bit 31, so it also fills the top word
   function automatic logic [63:0] pack_pair(input logic [15:0] hi, input logic [15:0] lo);
      return sext32({hi, lo});
   endfunction : pack_pair

   // only the non-halving forms may raise the overflow flag
   function automatic logic raises_flag(input sub_op_e o, input logic h_ovf, input logic w_ovf);
      logic r;
      r = 1'b0;
      case (o)
         OP_HPS:     r = h_ovf;
         OP_HPS_SAT: r = h_ovf;
         OP_WS_SAT:  r = w_ovf;
         default:    r = 1'b0;
      endcase
      return r;
   endfunction : raises_flag

   // ------------------------------------------------------------
   // lanes
   // ------------------------------------------------------------
   // lane 0 is the low halfword, lane 1 the upper one
   logic [15:0] wrap_l   [N_LANES];
   logic [15:0] sat_l    [N_LANES];
   logic [15:0] half_l   [N_LANES];
   logic [15:0] half_r_l [N_LANES];
   logic        ovf_l    [N_LANES];

   genvar gi;
   generate
      for (gi = 0; gi < N_LANES; gi++) begin : g_lane
         half_sub_lane u_lane (
            .a_in           (first_source_in[gi*LANE_W +: LANE_W]),
            .b_in           (second_source_in[gi*LANE_W +: LANE_W]),
            .wrap_out       (wrap_l[gi]),
            .sat_out        (sat_l[gi]),
            .half_out       (half_l[gi]),
            .half_round_out (half_r_l[gi]),
            .ovf_out        (ovf_l[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // word path
   // ------------------------------------------------------------
   // 33 bits, so a signed overflow shows as bit 32 disagreeing with bit 31
   logic [32:0] wa_ext;
   logic [32:0] wb_ext;
   logic [32:0] wdiff;
   logic [32:0] wdiff_r;
   logic        wovf;
   logic [31:0] wsat;
   assign wa_ext  = {first_source_in[WORD_W-1], first_source_in[WORD_W-1:0]};
   assign wb_ext  = {second_source_in[WORD_W-1], second_source_in[WORD_W-1:0]};
   assign wdiff   = wa_ext - wb_ext;
   assign wdiff_r = wdiff + 33'h000000001;
   assign wovf    = wdiff[32] ^ wdiff[31];
   assign wsat    = wovf ? (wdiff[32] ? WORD_MIN : WORD_MAX) : wdiff[31:0];

   // ------------------------------------------------------------
   // decode and flag decision
   // ------------------------------------------------------------
   sub_op_e op;
   logic    any_half_ovf;
   logic    flag_set;
   assign op           = decode_op(instr_in);
   assign any_half_ovf = ovf_l[0] | ovf_l[1];
   assign flag_set     = issue_valid_in & raises_flag(op, any_half_ovf, wovf);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic [63:0] result;
      logic [31:0] ctrl;
   } state_s;

   state_s st_ff;
   state_s nxt_st;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.valid = 1'b0;
      // software write first, so a same-cycle overflow still sets the flag
      if (ctrl_wr_in) begin
         nxt_st.ctrl = ctrl_wdata_in;
      end
      // overflow only reported via flag or clamp, never a trap
      if (issue_valid_in) begin
         nxt_st.valid = (op != OP_NONE);
         case (op)
            OP_HPS: begin
               nxt_st.result = pack_pair(wrap_l[1], wrap_l[0]);
            end
            OP_HPS_SAT: begin
               nxt_st.result = pack_pair(sat_l[1], sat_l[0]);
            end
            OP_WS_SAT: begin
               nxt_st.result = sext32(wsat);
            end
            OP_HH: begin
               nxt_st.result = pack_pair(half_l[1], half_l[0]);
            end
            OP_HH_R: begin
               nxt_st.result = pack_pair(half_r_l[1], half_r_l[0]);
            end
            OP_HW: begin
               nxt_st.result = sext32(wdiff[32:1]);
            end
            OP_HW_R: begin
               nxt_st.result = sext32(wdiff_r[32:1]);
            end
            // unrecognised words leave the last result standing
            default: begin
               nxt_st.result = st_ff.result;
            end
         endcase
      end
      // halving forms never reach the set, so their control word stands
      if (flag_set) begin
         nxt_st.ctrl[OUFLAG_SUB_BIT] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // control word clears with the rest so no stale flag survives reset
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         st_ff.valid  <= 1'b0;
         st_ff.result <= '0;
         st_ff.ctrl   <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign result_valid_out        = st_ff.valid;
   assign result_out              = st_ff.result;
   assign sigproc_control_reg_out = st_ff.ctrl;
endmodule : fractional_subtract_unit

/* File: dv/fsu_chk.sv */
// port-level assertions for the fractional subtract unit
`timescale 1ns/1ps
module fsu_chk (
   // clock and reset
   input wire logic        core_clk_in,
   input wire logic        srst_in,
   // issue side
   input wire logic        issue_valid_in,
   input wire logic        ctrl_wr_in,
   input wire logic [31:0] instr_in,
   input wire logic [63:0] first_source_in,
   input wire logic [63:0] second_source_in,
   // results
   input wire logic        result_valid_out,
   input wire logic [63:0] result_out,
   input wire logic [31:0] sigproc_control_reg_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   logic [32:0] d;
   logic [16:0] h;
   logic [31:0] ws_exp;
   logic [31:0] hw_exp;
   logic [15:0] hh_exp;
   logic        ar, hv, rec;
   assign d = {first_source_in[31], first_source_in[31:0]} - {second_source_in[31], second_source_in[31:0]};
   assign h = {first_source_in[15], first_source_in[15:0]} - {second_source_in[15], second_source_in[15:0]};
   assign ws_exp = d[32] != d[31] ? {d[32], {31{!d[32]}}} : d[31:0];
   assign hw_exp = d[32:1];
   assign hh_exp = h[16:1];
   assign ar = issue_valid_in && instr_in[31:26] == 6'h1f && instr_in[5:0] == 6'h10;
   assign hv = issue_valid_in && instr_in[31:26] == 6'h1f && instr_in[5:0] == 6'h18;
   assign rec = ar && instr_in[10:6] inside {5'h0b, 5'h0f, 5'h17}
                || hv && instr_in[10:6] inside {5'h09, 5'h0b, 5'h11, 5'h13};
   property p_dec; rec |=> result_valid_out; endproperty
   a_dec: assert property (p_dec) else $error("valid missing");
   property p_ref; !rec |=> !result_valid_out; endproperty
   a_ref: assert property (p_ref) else $error("stray valid");
   property p_ws; ar && instr_in[10:6] == 5'h17
      |=> result_out[31:0] == $past(ws_exp); endproperty
   a_ws: assert property (p_ws) else $error("bad word sat");
   property p_flag; ar && instr_in[10:6] == 5'h17 && d[32] != d[31] |=> sigproc_control_reg_out[20]; endproperty
   a_flag: assert property (p_flag) else $error("flag not set");
   property p_keep; hv && !ctrl_wr_in |=> $stable(sigproc_control_reg_out); endproperty
   a_keep: assert property (p_keep) else $error("control changed");
   property p_hw; hv && instr_in[10:6] == 5'h11 |=> result_out[31:0] == $past(hw_exp); endproperty
   a_hw: assert property (p_hw) else $error("bad halving word");
   property p_hh; hv && instr_in[10:6] == 5'h09 |=> result_out[15:0] == $past(hh_exp); endproperty
   a_hh: assert property (p_hh) else $error("bad halving half");
   property p_sx; result_valid_out |-> result_out[63:32] == {32{result_out[31]}}; endproperty
   a_sx: assert property (p_sx) else $error("bad sign extension");
endmodule : fsu_chk
bind fractional_subtract_unit fsu_chk chk_u (.*);

/* File: dv/pipe_issue_model.sv */
// pipeline issue model presenting requests to the subtract unit
`timescale 1ns/1ps
module pipe_issue_model (
   // request to the unit
   output logic        valid_out,
   output logic [31:0] instr_out,
   output logic [63:0] a_out,
   output logic [63:0] b_out
);
   // idle cycles show flipped values so stale operands cannot pass
   task automatic drive(input logic v, input logic [31:0] i, input logic [63:0] a, input logic [63:0] b);
      valid_out = v;
      {instr_out, a_out, b_out} = v ? {i, a, b} : ~{i, a, b};
   endtask : drive
endmodule : pipe_issue_model

/* File: dv/fractional_subtract_unit_bench.sv */
// random self-checking bench for the fractional subtract unit
`timescale 1ns/1ps
module fractional_subtract_unit_bench;
   logic        core_clk_in, srst_in, issue_valid_in, ctrl_wr_in, result_valid_out;
   logic [31:0] instr_in, ctrl_wdata_in, sigproc_control_reg_out, exp_ctrl;
   logic [63:0] first_source_in, second_source_in, result_out, av, bv;
   logic [95:0] exp_q[$];
   logic [95:0] exp_v;
   logic [10:0] ops[10] = '{11'h5d0, 11'h2d0, 11'h3d0, 11'h258, 11'h2d8, 11'h458, 11'h4d8, 11'h790, 11'h798, 11'h5d0};
   int          n_errors, checks, k;
   fractional_subtract_unit dut_u (.*);
   pipe_issue_model pm_u (.valid_out(issue_valid_in), .instr_out(instr_in), .a_out(first_source_in),
                          .b_out(second_source_in));
   // o is {sub-operation, function}; returns {control, result}
   function automatic logic [95:0] model(input logic [10:0] o, input logic [63:0] a, b, input logic [31:0] c);
      logic [32:0] d, h, w;
      logic        v;
      d = {a[31], a[31:0]} - {b[31], b[31:0]};
      v = o == 11'h5d0 && d[32] != d[31];
      for (int j = 0; j < 32; j += 16) begin
         h = {a[j+15], a[j+:16]} - {b[j+15], b[j+:16]} + (o[3] & o[7]);
         v |= !o[3] && !o[10] && h[16] != h[15];
         w[j+:16] = o[3] ? h[16:1] : (o[8] && h[16] != h[15] ? {h[16], {15{!h[16]}}} : h[15:0]);
      end
      d = d + (o[3] & o[7]);
      if (o[10]) w = o[3] ? d[32:1] : (d[32] != d[31] ? {d[32], {31{!d[32]}}} : d[31:0]);
      return {c | {11'h0, v, 20'h0}, {32{w[31]}}, w[31:0]};
   endfunction : model
   task automatic check(input logic [95:0] got, input logic [95:0] exp);
      checks++;
      if (got !== exp) $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
      n_errors += (got !== exp);
   endtask : check
   task automatic end_of_test();
      if (n_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   initial begin
      core_clk_in = 1'b0;
      forever #2 core_clk_in = ~core_clk_in;
   end
   // valid lasts one full cycle, so the falling edge sees every result settled
   always @(negedge core_clk_in)
      if (result_valid_out === 1'b1) begin
         exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
         check(96'(result_out[31:0]), 96'(exp_v[31:0]));
         check(96'(result_out[63:32]), 96'(exp_v[63:32]));
         check(96'(sigproc_control_reg_out), 96'(exp_v[95:64]));
      end
   initial begin
      #6000 n_errors++;
      end_of_test();
   end
   initial begin
      void'($urandom(651));
      {srst_in, ctrl_wr_in, ctrl_wdata_in, exp_ctrl} = {1'b1, 65'h0};
      pm_u.drive(1'b0, '0, '0, '0);
      repeat (2) @(negedge core_clk_in);
      srst_in = 1'b0;
      repeat (400) begin
         k = $urandom_range(9);
         av = {$urandom(), $urandom()};
         bv = {$urandom(), $urandom()};
         ctrl_wr_in = $urandom_range(7) == 0;
         ctrl_wdata_in = $urandom();
         pm_u.drive(1'b1, {k == 9 ? 6'h1e : 6'h1f, 15'($urandom()), ops[k]}, av, bv);
         if (k < 7) exp_q.push_back(model(ops[k], av, bv, ctrl_wr_in ? ctrl_wdata_in : exp_ctrl));
         exp_ctrl = k < 7 ? exp_q[$][95:64] : ctrl_wr_in ? ctrl_wdata_in : exp_ctrl;
         @(negedge core_clk_in);
      end
      pm_u.drive(1'b0, '0, '0, '0);
      ctrl_wr_in = 1'b0;
      repeat (2) @(negedge core_clk_in);
      check(96'(exp_q.size()), '0);
      end_of_test();
   end
endmodule : fractional_subtract_unit_bench
